// >>> hpt_lib_model.sv
/*
 * Waveform library model: answers each fetch with one final segment.
 * Assumes the drive output falls to zero when the segment hold ends.
 */
`timescale 1ns/1ps
module hpt_lib_model (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              lib_req_i,
	input  wire logic signed [7:0] drive_i,
	input  wire logic signed [7:0] amp_i,
	input  wire logic signed [7:0] peak_i,
	input  wire logic        [7:0] dur_i,
	output logic                   valid_o,
	output hpt_pkg::hpt_seg_t      seg_o,
	output logic signed      [7:0] peak_o
);
	// ==========================================================
	// Segment hold and release
	logic seen;
	logic idle;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			valid_o <= 1'b0;
			seg_o   <= '0;
			peak_o  <= 8'h00;
			seen    <= 1'b0;
			idle    <= 1'b0;
		end else if (lib_req_i) begin
			valid_o <= 1'b1;
			seg_o   <= '{amp_i, dur_i, 1'b1};
			peak_o  <= peak_i;
			seen    <= 1'b0;
			idle    <= 1'b0;
		end else if (valid_o && drive_i != 8'h00) begin
			seen <= 1'b1;
		end else if (valid_o && (seen || idle)) begin
			// Released lines show the inverse, not stale data
			valid_o <= 1'b0;
			seg_o   <= ~seg_o;
			peak_o  <= ~peak_o;
		end else if (valid_o) begin
			// Segment taken without drive (clamped): release next cycle
			idle <= 1'b1;
		end
	end
endmodule // hpt_lib_model

// >>> hpt_pkg.sv
/*
 * Package of the haptic playback trigger and timing block: register map,
 * reset values, mode codes, timing constants and the segment carrier.
 * Assumes a 10 MHz system clock.
 */
package hpt_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_MODE     = 8'h01;
	localparam logic [7:0] ADDR_SLOT0    = 8'h04;
	localparam logic [7:0] ADDR_SLOT7    = 8'h0B;
	localparam logic [7:0] ADDR_FIRE     = 8'h0C;
	localparam logic [7:0] ADDR_OD_ADJ   = 8'h0D;
	localparam logic [7:0] ADDR_PS_ADJ   = 8'h0E;
	localparam logic [7:0] ADDR_NS_ADJ   = 8'h0F;

	// ==========================================================
	// Field positions and reset values
	localparam int         FIRE_BIT      = 0;
	localparam int         WAIT_BIT      = 7;
	localparam int         SLOT_COUNT    = 8;
	localparam logic [7:0] RST_ADJ       = 8'h00;
	localparam logic [7:0] RST_SLOT      = 8'h00;
	localparam logic [2:0] RST_MODE      = 3'h0;

	// ==========================================================
	// Operating-select codes
	localparam logic [2:0] MODE_SW       = 3'h0;
	localparam logic [2:0] MODE_EXT_EDGE = 3'h1;
	localparam logic [2:0] MODE_EXT_LVL  = 3'h2;
	localparam logic [2:0] MODE_DIAG     = 3'h6;
	localparam logic [2:0] MODE_CAL      = 3'h7;

	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int STEP_MS       = 5;
	localparam int WAIT_MS       = 10;
	localparam int STEP_CYCLES   = CLK_HZ / 1000 * STEP_MS;
	localparam int WAIT_CYCLES   = CLK_HZ / 1000 * WAIT_MS;

	// ==========================================================
	// Library segment carrier and register request
	typedef struct packed {
		logic signed [7:0] amp;
		logic        [7:0] dur;
		logic              last;
	} hpt_seg_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpt_reg_req_t;

endpackage

// >>> hpt_top.sv
/*
 * Playback fire control, waveform sequencer walk and segment time offsets, overdrive in open loop only.
 * Assumes a register port behind the serial interface, a waveform library
 * that answers a request with segments plus the peak amplitude, and
 * calibration and diagnostic engines that report completion.
 */
// How it works
// [R1] Writing one to the fire bit starts the process that the mode picks.
// [R2] In sequencer modes the fire bit plays the identifiers in the slots.
// [R3] The fire bit reads one while playing and drops by itself at the end.
// [R4] Writing zero to the fire bit during playback aborts the sequence.
// [R5] In external trigger modes the trigger pin sets or clears the fire bit.
// [R6] Calibration and diagnostic modes launch their procedure instead.
// [R7] The overdrive offset is signed and adds 5 ms per count to overdrive.
// [R8] The segment whose amplitude equals the waveform peak is overdrive.
// [R9] The overdrive offset only applies in open loop and is ignored else.
// [R10] Other positive segments are positive sustain.
// [R11] The positive sustain offset is signed and moves it 5 ms per count.
// [R12] Other negative segments are negative sustain.
// [R13] The negative sustain offset is signed and moves it 5 ms per count.
// [R14] Slots play in order and stop at a zero identifier or after eight.
// [R15] A slot with its wait flag idles for 10 ms times its seven-bit value, or 10 ms when that value is zero.
// [R16] A negative offset longer than the segment clamps it to zero.
`timescale 1ns/1ps
module hpt_top #(
	parameter int STEP_CYC = hpt_pkg::STEP_CYCLES,
	parameter int WAIT_CYC = hpt_pkg::WAIT_CYCLES
) (
	input  wire logic              clk_i,
	input  wire logic              reset_n_i,
	input  wire hpt_pkg::hpt_reg_req_t reg_req_i,
	output logic            [7:0]  reg_rdata_o,
	input  wire logic              trig_i,
	input  wire logic              open_loop_i,
	output logic                   lib_req_o,
	output logic            [6:0]  lib_id_o,
	input  wire logic              lib_valid_i,
	input  wire hpt_pkg::hpt_seg_t lib_seg_i,
	input  wire logic signed [7:0] lib_peak_i,
	output logic signed     [7:0]  drive_o,
	output logic                   cal_start_o,
	output logic                   diag_start_o,
	input  wire logic              proc_done_i
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_SLOT, ST_SEG, ST_HOLD, ST_WAIT, ST_PROC
	} hpt_state_t;

	hpt_state_t        state_reg;
	logic [7:0]        slot_reg [hpt_pkg::SLOT_COUNT];
	logic [2:0]        mode_reg;
	logic signed [7:0] od_adj_reg;
	logic signed [7:0] ps_adj_reg;
	logic signed [7:0] ns_adj_reg;
	logic              fire_reg;
	logic [3:0]        idx_reg;
	logic [16:0]       tick_reg;
	logic [9:0]        units_reg;
	logic [2:0]        trig_sync_reg;
	logic              trig_reg;
	logic              trig_prev_reg;
	logic              fire_wr;
	logic              fire_set;
	logic              fire_clr;
	logic              done;
	logic [7:0]        entry;
	logic signed [7:0] seg_adj;
	logic signed [9:0] seg_sum;
	logic [9:0]        seg_units;
	logic              ext_mode;

	// ==========================================================
	// Trigger pin synchroniser
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trig_sync_reg <= 3'h0;
			trig_reg      <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_sync_reg <= {trig_sync_reg[1:0], trig_i};
			if (trig_sync_reg[1] == trig_sync_reg[2])
				trig_reg <= trig_sync_reg[2];
			trig_prev_reg <= trig_reg;
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_reg   <= hpt_pkg::RST_MODE;
			od_adj_reg <= hpt_pkg::RST_ADJ;
			ps_adj_reg <= hpt_pkg::RST_ADJ;
			ns_adj_reg <= hpt_pkg::RST_ADJ;
			for (int i = 0; i < hpt_pkg::SLOT_COUNT; i++)
				slot_reg[i] <= hpt_pkg::RST_SLOT;
		end else if (reg_req_i.wr) begin
			unique case (reg_req_i.addr)
				hpt_pkg::ADDR_MODE:   mode_reg   <= reg_req_i.wdata[2:0];
				hpt_pkg::ADDR_OD_ADJ: od_adj_reg <= reg_req_i.wdata;
				hpt_pkg::ADDR_PS_ADJ: ps_adj_reg <= reg_req_i.wdata;
				hpt_pkg::ADDR_NS_ADJ: ns_adj_reg <= reg_req_i.wdata;
				default: begin
					if (reg_req_i.addr >= hpt_pkg::ADDR_SLOT0 &&
					    reg_req_i.addr <= hpt_pkg::ADDR_SLOT7)
						slot_reg[reg_req_i.addr[2:0] - 3'h4] <= reg_req_i.wdata;
				end
			endcase
		end
	end

	// ==========================================================
	// Register reads
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				hpt_pkg::ADDR_MODE:   reg_rdata_o <= {5'h00, mode_reg};
				hpt_pkg::ADDR_FIRE:   reg_rdata_o <= {7'h00, fire_reg}; // R3
				hpt_pkg::ADDR_OD_ADJ: reg_rdata_o <= od_adj_reg;
				hpt_pkg::ADDR_PS_ADJ: reg_rdata_o <= ps_adj_reg;
				hpt_pkg::ADDR_NS_ADJ: reg_rdata_o <= ns_adj_reg;
				default: begin
					if (reg_req_i.addr >= hpt_pkg::ADDR_SLOT0 &&
					    reg_req_i.addr <= hpt_pkg::ADDR_SLOT7)
						reg_rdata_o <= slot_reg[reg_req_i.addr[2:0] - 3'h4];
					else
						reg_rdata_o <= 8'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// Fire bit
	assign ext_mode = (mode_reg == hpt_pkg::MODE_EXT_EDGE) ||
	                  (mode_reg == hpt_pkg::MODE_EXT_LVL);
	assign fire_wr  = reg_req_i.wr && reg_req_i.addr == hpt_pkg::ADDR_FIRE;
	always_comb begin
		fire_set = fire_wr && reg_req_i.wdata[hpt_pkg::FIRE_BIT]; // R1
		fire_clr = (fire_wr && !reg_req_i.wdata[hpt_pkg::FIRE_BIT]) || done; // R4
		if (mode_reg == hpt_pkg::MODE_EXT_EDGE && trig_reg && !trig_prev_reg)
			fire_set = 1'b1; // R5
		if (mode_reg == hpt_pkg::MODE_EXT_LVL) begin
			fire_set = fire_set || (trig_reg && !trig_prev_reg); // R5
			fire_clr = fire_clr || (!trig_reg && trig_prev_reg); // R5
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			fire_reg <= 1'b0;
		else if (fire_set)
			fire_reg <= 1'b1;
		else if (fire_clr)
			fire_reg <= 1'b0; // R3
	end

	// ==========================================================
	// Segment classification and offset
	always_comb begin
		if (lib_seg_i.amp == lib_peak_i)
			seg_adj = open_loop_i ? od_adj_reg : 8'sh00; // R7 R8 R9
		else if (lib_seg_i.amp > 8'sh00)
			seg_adj = ps_adj_reg; // R10 R11
		else if (lib_seg_i.amp < 8'sh00)
			seg_adj = ns_adj_reg; // R12 R13
		else
			seg_adj = 8'sh00;
		seg_sum   = $signed({2'b00, lib_seg_i.dur}) + 10'(seg_adj);
		seg_units = seg_sum[9] ? 10'h000 : seg_sum; // R16
	end

	// ==========================================================
	// Playback engine
	assign entry = (idx_reg < 4'(hpt_pkg::SLOT_COUNT)) ?
	               slot_reg[idx_reg[2:0]] : 8'h00;
	assign done  = (state_reg == ST_SLOT && entry == 8'h00) ||
	               (state_reg == ST_PROC && proc_done_i);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg    <= ST_IDLE;
			idx_reg      <= 4'h0;
			tick_reg     <= 17'h0_0000;
			units_reg    <= 10'h000;
			lib_req_o    <= 1'b0;
			lib_id_o     <= 7'h00;
			drive_o      <= 8'sh00;
			cal_start_o  <= 1'b0;
			diag_start_o <= 1'b0;
		end else begin
			lib_req_o    <= 1'b0;
			cal_start_o  <= 1'b0;
			diag_start_o <= 1'b0;
			if (!fire_reg && state_reg != ST_IDLE) begin
				state_reg <= ST_IDLE; // R4
				drive_o   <= 8'sh00;
			end else begin
				unique case (state_reg)
					ST_IDLE: if (fire_reg) begin
						idx_reg <= 4'h0;
						if (mode_reg == hpt_pkg::MODE_CAL) begin
							cal_start_o <= 1'b1; // R6
							state_reg   <= ST_PROC;
						end else if (mode_reg == hpt_pkg::MODE_DIAG) begin
							diag_start_o <= 1'b1; // R6
							state_reg    <= ST_PROC;
						end else begin
							state_reg <= ST_SLOT; // R2
						end
					end
					ST_SLOT: begin
						drive_o <= 8'sh00;
						if (entry == 8'h00) begin
							state_reg <= ST_IDLE; // R14
						end else if (entry[hpt_pkg::WAIT_BIT]) begin
							units_reg <= {3'h0, entry[6:0]}; // R15
							tick_reg  <= 17'(WAIT_CYC - 1);
							state_reg <= ST_WAIT;
						end else begin
							lib_req_o <= 1'b1; // R2
							lib_id_o  <= entry[6:0];
							state_reg <= ST_SEG;
						end
					end
					ST_SEG: if (lib_valid_i) begin
						if (seg_units != 10'h000) begin
							drive_o   <= lib_seg_i.amp;
							units_reg <= seg_units;
							tick_reg  <= 17'(STEP_CYC - 1);
							state_reg <= ST_HOLD;
						end else if (lib_seg_i.last) begin
							idx_reg   <= idx_reg + 4'h1; // R14
							state_reg <= ST_SLOT;
						end
					end
					ST_HOLD, ST_WAIT: begin
						if (tick_reg != 17'h0_0000) begin
							tick_reg <= tick_reg - 17'h0_0001;
						end else if (units_reg > 10'h001) begin
							units_reg <= units_reg - 10'h001;
							tick_reg  <= (state_reg == ST_WAIT) ?
							             17'(WAIT_CYC - 1) : 17'(STEP_CYC - 1);
						end else if (state_reg == ST_HOLD && !lib_seg_i.last) begin
							drive_o   <= 8'sh00;
							state_reg <= ST_SEG;
						end else begin
							units_reg <= 10'h000;
							drive_o   <= 8'sh00;
							idx_reg   <= idx_reg + 4'h1; // R14
							state_reg <= ST_SLOT;
						end
					end
					ST_PROC: if (proc_done_i)
						state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Checks
	sequence fire_write_s;
		fire_wr && reg_req_i.wdata[0] && !fire_reg;
	endsequence

	fire_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		fire_write_s |=> fire_reg) // R1
		else $error("Fire write did not set the fire bit");
	play_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == ST_IDLE && fire_reg && mode_reg == hpt_pkg::MODE_SW)
		|=> state_reg == ST_SLOT && idx_reg == 4'h0) // R2
		else $error("Sequencer did not start at slot zero");
	fire_drop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == ST_SLOT && entry == 8'h00 && !fire_set)
		|=> !fire_reg && state_reg == ST_IDLE) // R3
		else $error("Fire bit stayed set after playback end");
	abort_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(fire_wr && !reg_req_i.wdata[0] && !fire_set && state_reg == ST_HOLD)
		|=> ##1 state_reg == ST_IDLE && drive_o == 8'sh00) // R4
		else $error("Clearing fire did not abort playback");
	ext_edge_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(mode_reg == hpt_pkg::MODE_EXT_EDGE && $rose(trig_reg))
		|=> fire_reg) // R5
		else $error("Trigger edge did not set fire bit");
	proc_launch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == ST_IDLE && fire_reg && mode_reg == hpt_pkg::MODE_CAL)
		|=> cal_start_o && !lib_req_o) // R6
		else $error("Calibration was not launched");
	od_closed_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!open_loop_i && lib_seg_i.amp == lib_peak_i)
		|-> seg_units == {2'b00, lib_seg_i.dur}) // R9
		else $error("Overdrive offset used in closed loop");
	clamp_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == ST_SEG && lib_valid_i && seg_sum[9])
		|=> state_reg != ST_HOLD) // R16
		else $error("Negative duration was not clamped");
	slot_limit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		idx_reg <= 4'(hpt_pkg::SLOT_COUNT)) // R14
		else $error("Slot index ran past the last slot");

endmodule // hpt_top

// >>> tb_top.sv
/*
 * Self-checking bench of the playback trigger and timing block.
 * Assumes short step and wait counts set through the top parameters.
 */
`timescale 1ns/1ps
module tb_top;
	localparam int SC = 4;
	logic clk_i = 0, reset_n_i = 0, trig_i = 0;
	logic open_loop_i = 0, proc_done_i = 0;
	hpt_pkg::hpt_reg_req_t reg_req_i = '0;
	hpt_pkg::hpt_seg_t lib_seg_i;
	logic [7:0] reg_rdata_o, rd_v, m_dur = 0;
	logic [6:0] lib_id_o;
	logic lib_req_o, lib_valid_i, cal_start_o, diag_start_o;
	logic signed [7:0] lib_peak_i, drive_o, m_amp = 0, m_peak = 0;
	int fails = 0, checks_done = 0, ndrive = 0, nreq = 0, nstart = 0;

	hpt_top #(.STEP_CYC(SC), .WAIT_CYC(8)) u_hpt_top (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o), .trig_i(trig_i),
		.open_loop_i(open_loop_i), .lib_req_o(lib_req_o),
		.lib_id_o(lib_id_o), .lib_valid_i(lib_valid_i),
		.lib_seg_i(lib_seg_i), .lib_peak_i(lib_peak_i),
		.drive_o(drive_o), .cal_start_o(cal_start_o),
		.diag_start_o(diag_start_o), .proc_done_i(proc_done_i));
	hpt_lib_model u_hpt_lib_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.lib_req_i(lib_req_o), .drive_i(drive_o), .amp_i(m_amp),
		.peak_i(m_peak), .dur_i(m_dur), .valid_o(lib_valid_i),
		.seg_o(lib_seg_i), .peak_o(lib_peak_i));

	// ==========================================================
	// Clock, monitors and watchdog
	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (drive_o !== 8'h00) ndrive++;
		if (lib_req_o === 1'b1) nreq++;
		if (cal_start_o === 1'b1) nstart += 2;
		if (diag_start_o === 1'b1) nstart++;
	end
	initial begin
		#(40000 * 100);
		fails++;
		tally_and_finish();
	end

	// ==========================================================
	// Tasks and reference model
	task automatic tally_and_finish();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_req_i <= '{1'b1, 1'b0, a, d};
		cyc(1);
		reg_req_i <= '0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		reg_req_i <= '0;
		cyc(1);
		rd_v = reg_rdata_o;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk(rd_v, exp);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			rd(8'h0C);
			if (rd_v === 8'h00) break;
		end
		chk(rd_v, 8'h00);
	endtask
	function automatic int exp_len(int amp, peak, dur, ol, od, ps, ns);
		int adj = 0;
		if (amp == peak) adj = ol ? od : 0;
		else if (amp > 0) adj = ps;
		else if (amp < 0) adj = ns;
		return (dur + adj < 0) ? 0 : (dur + adj) * SC;
	endfunction

	// ==========================================================
	// Scenarios
	initial begin
		int ta[5] = '{40, 40, 30, -30, -30};
		int tp[5] = '{40, 40, 60, 60, 60};
		int od, ps, ns, du, e;
		void'($urandom(35));
		cyc(8);
		reset_n_i = 1;
		for (int a = 12; a < 16; a++) rdc(8'(a), 8'h00);
		rdc(8'h20, 8'h00);
		wr(8'h04, 8'h03);
		wr(8'h05, 8'h00);
		for (int i = 0; i < 5; i++) begin
			od = int'($urandom_range(4)) - 2;
			ps = int'($urandom_range(4)) - 2;
			ns = (i == 4) ? -3 : int'($urandom_range(4)) - 2;
			du = (i == 4) ? 1 : 3 + int'($urandom_range(3));
			m_amp = 8'(ta[i]);
			m_peak = 8'(tp[i]);
			m_dur = 8'(du);
			open_loop_i = (i != 1);
			wr(8'h0D, 8'(od));
			wr(8'h0E, 8'(ps));
			wr(8'h0F, 8'(ns));
			rdc(8'h0D, 8'(od));
			e = exp_len(ta[i], tp[i], du, open_loop_i, od, ps, ns);
			ndrive = 0;
			nreq = 0;
			wr(8'h0C, 8'h01);
			if (e > 0) rdc(8'h0C, 8'h01);
			wait_idle();
			chk(8'(ndrive), 8'(e));
			chk(8'(nreq), 8'h01);
		end
		m_amp = 8'sd20;
		m_dur = 8'd200;
		wr(8'h0C, 8'h01);
		cyc(20);
		chk(drive_o, 8'h14);
		wr(8'h0C, 8'h00);
		cyc(5);
		chk(drive_o, 8'h00);
		rdc(8'h0C, 8'h00);
		wr(8'h01, 8'h01);
		trig_i = 1;
		cyc(3);
		trig_i = 0;
		cyc(10);
		rdc(8'h0C, 8'h01);
		wr(8'h0C, 8'h00);
		wr(8'h01, 8'h02);
		trig_i = 1;
		cyc(8);
		rdc(8'h0C, 8'h01);
		trig_i = 0;
		cyc(8);
		rdc(8'h0C, 8'h00);
		chk(drive_o, 8'h00);
		for (int m = 6; m < 8; m++) begin
			wr(8'h01, 8'(m));
			nstart = 0;
			wr(8'h0C, 8'h01);
			cyc(3);
			chk(8'(nstart), (m == 7) ? 8'h02 : 8'h01);
			chk({7'h00, (m == 7) ? cal_start_o : diag_start_o}, 8'h00);
			proc_done_i = 1;
			cyc(1);
			proc_done_i = 0;
			cyc(3);
			rdc(8'h0C, 8'h00);
		end
		wr(8'h01, 8'h00);
		m_dur = 8'd1;
		for (int s = 4; s < 12; s++) wr(8'(s), 8'(s - 3));
		nreq = 0;
		wr(8'h0C, 8'h01);
		wait_idle();
		chk(8'(nreq), 8'h08);
		wr(8'h04, 8'h82);
		wr(8'h05, 8'h00);
		nreq = 0;
		ndrive = 0;
		wr(8'h0C, 8'h01);
		cyc(14);
		rdc(8'h0C, 8'h01);
		cyc(4);
		rdc(8'h0C, 8'h00);
		chk(8'(nreq + ndrive), 8'h00);
		tally_and_finish();
	end
endmodule // tb_top
